/* design/usu_dev.sv */
// Shift unit device end: system-side command port and link-clocked shift engine
`timescale 1ns/100ps
`default_nettype none
module usu_dev (
    // System clock and reset
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    // Configuration levels
    input  wire logic [1:0]     mode_i,
    input  wire logic [1:0]     clk_src_i,
    input  wire logic           edge_select_bit_i,
    input  wire logic           dir_do_i,
    input  wire logic           dir_sck_i,
    // Software strobes
    input  wire logic           data_wr_i,
    input  wire logic [7:0]     data_i,
    input  wire logic           cnt_wr_i,
    input  wire logic [3:0]     cnt_i,
    input  wire logic           clr_ovf_i,
    input  wire logic           clr_start_i,
    input  wire logic           clock_toggle_strobe_i,
    input  wire logic           soft_clk_i,
    input  wire logic           timer_zero_match_i,
    // Status
    output logic [7:0]          serial_shift_register_o,
    output logic [7:0]          shift_copy_register_o,
    output logic [3:0]          cnt_o,
    output logic                counter_overflow_flag_o,
    output logic                start_detect_flag_o,
    output logic                hold_o,
    output logic                wake_o,
    // Pins
    usu_link_if.dev             link
);
    import usu_pkg::*;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] src;
        logic       edge_sel;
        logic       dir_do;
        logic       dir_sck;
        logic       dat_wr;
        logic [7:0] dat;
        logic       cnt_wr;
        logic [3:0] cnt;
        logic       clr_ovf;
        logic       clr_start;
        logic       toggle;
        logic       tick;
    } usu_cmd_t;

    typedef struct packed {
        logic [7:0] dat;
        logic [7:0] cpy;
        logic [3:0] cnt;
        logic       ovf;
        logic       start;
        logic       hold;
    } usu_stat_t;

    typedef struct packed {
        usu_cmd_t   pend;
        usu_cmd_t   cmd;
        logic       req;
        logic       ack1;
        logic       ack2;
        usu_stat_t  stat;
        logic       wake;
    } usu_sys_t;

    typedef struct packed {
        logic       r1;
        logic       r2;
        logic       ack;
        usu_stat_t  rsp;
        logic       s1;
        logic       s2;
        logic       s3;
        logic       d1;
        logic       d2;
        logic       d3;
        logic [1:0] mode;
        logic [1:0] src;
        logic       edge_sel;
        logic       dir_do;
        logic       dir_sck;
        logic [7:0] dat;
        logic [7:0] cpy;
        logic [3:0] cnt;
        logic       ovf;
        logic       start;
        logic       armed;
        logic       hold;
        logic       samp;
        logic       do_q;
        logic       sck_out;
        logic       o_sck;
        logic       o_sck_oe;
        logic       o_di_oe;
        logic       o_do;
        logic       o_do_oe;
    } usu_lnk_t;

    usu_sys_t sys_q;
    usu_sys_t sys_d;
    usu_lnk_t lnk_q;
    usu_lnk_t lnk_d;
    usu_cmd_t nw;
    logic     lrst_a_q;
    logic     lrst_q;

    // ************************************************************
    // System side: gather strobes, run the request/ack handshake
    // ************************************************************
    always_comb begin
        nw           = '0;
        nw.mode      = mode_i;
        nw.src       = clk_src_i;
        nw.edge_sel  = edge_select_bit_i;
        nw.dir_do    = dir_do_i;
        nw.dir_sck   = dir_sck_i;
        nw.dat_wr    = data_wr_i;
        nw.dat       = data_i;
        nw.cnt_wr    = cnt_wr_i;
        nw.cnt       = cnt_i;
        nw.clr_ovf   = clr_ovf_i;
        nw.clr_start = clr_start_i;
        nw.toggle    = clock_toggle_strobe_i;
        nw.tick      = (clk_src_i == SRC_TIMER && timer_zero_match_i) ||
                       (clk_src_i == SRC_SOFT && soft_clk_i);
        // Strobes arriving while a round is in flight are merged into the next one
        if (sys_q.pend.dat_wr && !data_wr_i) begin
            nw.dat_wr = 1'b1;
            nw.dat    = sys_q.pend.dat;
        end
        if (sys_q.pend.cnt_wr && !cnt_wr_i) begin
            nw.cnt_wr = 1'b1;
            nw.cnt    = sys_q.pend.cnt;
        end
        nw.clr_ovf   = nw.clr_ovf | sys_q.pend.clr_ovf;
        nw.clr_start = nw.clr_start | sys_q.pend.clr_start;
        nw.toggle    = nw.toggle | sys_q.pend.toggle;
        nw.tick      = nw.tick | sys_q.pend.tick;
    end

    always_comb begin
        sys_d      = sys_q;
        sys_d.ack1 = lnk_q.ack;
        sys_d.ack2 = sys_q.ack1;
        sys_d.pend = nw;
        if (!sys_q.req && !sys_q.ack2) begin
            sys_d.req  = 1'b1;
            sys_d.cmd  = nw;
            sys_d.pend = '0;
        end else if (sys_q.req && sys_q.ack2) begin
            sys_d.req  = 1'b0;
            sys_d.stat = lnk_q.rsp;
        end
        sys_d.wake = sys_d.stat.ovf | sys_d.stat.start;
        if (rst_i) begin
            sys_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        sys_q <= sys_d;
    end

    assign serial_shift_register_o = sys_q.stat.dat;
    assign shift_copy_register_o   = sys_q.stat.cpy;
    assign cnt_o                   = sys_q.stat.cnt;
    assign counter_overflow_flag_o = sys_q.stat.ovf;
    assign start_detect_flag_o     = sys_q.stat.start;
    assign hold_o                  = sys_q.stat.hold;
    assign wake_o                  = sys_q.wake;

    // ************************************************************
    // Link side reset synchroniser
    // ************************************************************
    always_ff @(posedge link.link_clk) begin
        lrst_a_q <= rst_i;
        lrst_q   <= lrst_a_q;
    end

    // ************************************************************
    // Link side: pin sampling, shift register, counter, clock hold
    // ************************************************************
    always_comb begin
        logic     rise;
        logic     fall;
        logic     ext;
        logic     tw;
        logic     apply;
        logic     tick;
        logic     samp_e;
        logic     shift_e;
        logic     count_e;
        logic     ovf_set;
        usu_cmd_t c;
        rise    = 1'b0;
        fall    = 1'b0;
        ext     = 1'b0;
        tw      = 1'b0;
        apply   = 1'b0;
        tick    = 1'b0;
        samp_e  = 1'b0;
        shift_e = 1'b0;
        count_e = 1'b0;
        ovf_set = 1'b0;
        c       = sys_q.cmd;
        lnk_d   = lnk_q;
        lnk_d.r1 = sys_q.req;
        lnk_d.r2 = lnk_q.r1;
        lnk_d.s1 = link.sck_line;
        lnk_d.s2 = lnk_q.s1;
        lnk_d.s3 = lnk_q.s2;
        lnk_d.d1 = link.di_line;
        lnk_d.d2 = lnk_q.d1;
        lnk_d.d3 = lnk_q.d2;
        rise  = lnk_q.s2 & ~lnk_q.s3;
        fall  = ~lnk_q.s2 & lnk_q.s3;
        tw    = lnk_q.mode == MODE_2W;
        ext   = lnk_q.src == SRC_PIN;
        apply = lnk_q.r2 & ~lnk_q.ack;
        tick  = apply & c.tick & ~ext;
        // Command round: answer with a snapshot, then take config and clears
        if (apply) begin
            lnk_d.ack = 1'b1;
            lnk_d.rsp = '{lnk_q.dat, lnk_q.cpy, lnk_q.cnt, lnk_q.ovf, lnk_q.start, lnk_q.hold};
            lnk_d.mode     = c.mode;
            lnk_d.src      = c.src;
            lnk_d.edge_sel = c.edge_sel;
            lnk_d.dir_do   = c.dir_do;
            lnk_d.dir_sck  = c.dir_sck;
            if (c.clr_ovf) begin
                lnk_d.ovf = 1'b0;
            end
            if (c.clr_start) begin
                lnk_d.start = 1'b0;
            end
            if (c.toggle) begin
                lnk_d.sck_out = ~lnk_q.sck_out;
            end
        end else if (!lnk_q.r2 && lnk_q.ack) begin
            lnk_d.ack = 1'b0;
        end
        // Edge roles follow the edge select bit
        samp_e  = ext & (lnk_q.edge_sel ? fall : rise);
        shift_e = ext & (lnk_q.edge_sel ? rise : fall);
        count_e = ext ? (rise | fall) : tick;
        if (samp_e) begin
            lnk_d.samp = lnk_q.d2;
        end
        if (shift_e) begin
            lnk_d.dat  = {lnk_q.dat[6:0], lnk_q.samp};
            lnk_d.do_q = lnk_q.dat[6];
        end else if (tick) begin
            lnk_d.dat  = {lnk_q.dat[6:0], lnk_q.d2};
            lnk_d.do_q = lnk_q.dat[6];
        end
        if (count_e) begin
            lnk_d.cnt = lnk_q.cnt + 4'h1;
            if (lnk_q.cnt == CNT_LAST) begin
                ovf_set   = 1'b1;
                lnk_d.ovf = 1'b1;
                lnk_d.cpy = lnk_d.dat;
            end
        end
        // Start condition: data falls while clock stays high
        if (tw && lnk_q.s2 && lnk_q.s3 && lnk_q.d3 && !lnk_q.d2) begin
            lnk_d.start = 1'b1;
            lnk_d.armed = 1'b1;
        end
        if (lnk_q.armed && fall) begin
            lnk_d.armed = 1'b0;
        end
        lnk_d.hold = tw & ((lnk_q.hold & (lnk_d.start | lnk_d.ovf)) |
                           (lnk_q.armed & fall) | ovf_set);
        // Software writes win over a shift in the same cycle
        if (apply && c.dat_wr) begin
            lnk_d.dat  = c.dat;
            lnk_d.do_q = c.dat[7];
        end
        if (apply && c.cnt_wr) begin
            lnk_d.cnt = c.cnt;
        end
        // Pin drivers
        lnk_d.o_do     = lnk_d.do_q;
        lnk_d.o_do_oe  = (lnk_d.mode == MODE_3W) & lnk_d.dir_do;
        lnk_d.o_di_oe  = (lnk_d.mode == MODE_2W) & lnk_d.dir_do & ~lnk_d.do_q;
        lnk_d.o_sck    = lnk_d.sck_out & ~lnk_d.hold;
        lnk_d.o_sck_oe = ((lnk_d.mode != MODE_OFF) & lnk_d.dir_sck) | lnk_d.hold;
        if (lrst_q) begin
            lnk_d = '0;
            // Released lines float high; starting the edge detectors there avoids a false edge
            {lnk_d.s1, lnk_d.s2, lnk_d.s3, lnk_d.d1, lnk_d.d2, lnk_d.d3} = 6'h3f;
        end
    end

    always_ff @(posedge link.link_clk) begin
        lnk_q <= lnk_d;
    end

    assign link.d_sck    = lnk_q.o_sck;
    assign link.d_sck_oe = lnk_q.o_sck_oe;
    assign link.d_di     = 1'b0;
    assign link.d_di_oe  = lnk_q.o_di_oe;
    assign link.d_do     = lnk_q.o_do;
    assign link.d_do_oe  = lnk_q.o_do_oe;

endmodule
`default_nettype wire

/* design/usu_host.sv */
// Far end: serial master that makes the clock by dividing its own clock
`timescale 1ns/100ps
`default_nettype none
module usu_host (
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    // Command
    input  wire logic           cmd_valid_i,
    input  wire logic [1:0]     cmd_i,
    input  wire logic [7:0]     tx_i,
    input  wire logic           ack_bit_i,
    input  wire logic           two_wire_i,
    input  wire logic           edge_select_bit_i,
    // Answer
    output logic                cmd_ready_o,
    output logic                done_o,
    output logic [7:0]          rx_o,
    output logic                ack_rx_o,
    // Pins
    usu_link_if.host            link
);
    import usu_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LEAD, H_HIGH, H_STA, H_STO} usu_hst_t;

    typedef struct packed {
        usu_hst_t   st;
        logic       tw;
        logic [1:0] ph;
        logic [8:0] sh;
        logic [3:0] bits;
        logic [2:0] tmr;
        logic       k1;
        logic       k2;
        logic       i1;
        logic       i2;
        logic       lvl;
        logic       dat;
        logic       ready;
        logic       done;
        logic [7:0] rx;
        logic       ackr;
        logic       o_sck;
        logic       o_sck_oe;
        logic       o_dat;
        logic       o_dat_oe;
    } usu_host_t;

    usu_host_t q;
    usu_host_t d;

    // ************************************************************
    // Clock and data sequencer
    // ************************************************************
    always_comb begin
        logic tdone;
        d      = q;
        tdone  = q.tmr == 3'h0;
        d.k1   = link.sck_line;
        d.k2   = q.k1;
        d.i1   = q.tw ? link.di_line : link.do_line;
        d.i2   = q.i1;
        d.done = 1'b0;
        if (!tdone) begin
            d.tmr = q.tmr - 3'h1;
        end
        case (q.st)
            H_IDLE: begin
                d.ready = 1'b1;
                // Three-wire clock rests at its mode's idle level, so a command starts with no stray edge
                if (!two_wire_i) begin
                    d.lvl = edge_select_bit_i;
                end
                if (cmd_valid_i && q.ready) begin
                    d.ready = 1'b0;
                    d.tw    = two_wire_i;
                    d.tmr   = SCK_HALF_LD;
                    d.ph    = 2'h0;
                    if (cmd_i == CMD_START) begin
                        d.lvl = 1'b1;
                        d.dat = 1'b1;
                        d.st  = H_STA;
                    end else if (cmd_i == CMD_STOP) begin
                        d.dat = 1'b0;
                        d.st  = H_STO;
                    end else begin
                        d.sh   = {tx_i, ack_bit_i};
                        d.bits = (cmd_i == CMD_BYTE) ? FRAME_BITS : XFER_BITS;
                        d.dat  = tx_i[7];
                        if (!two_wire_i) begin
                            d.lvl = edge_select_bit_i;
                        end
                        d.st = H_SETUP;
                    end
                end
            end
            H_SETUP: begin
                if (tdone) begin
                    d.lvl = ~q.lvl;
                    d.st  = H_LEAD;
                end
            end
            H_LEAD: begin
                if (q.k2 == q.lvl) begin
                    d.tmr = SCK_HALF_LD;
                    d.st  = H_HIGH;
                end
            end
            H_HIGH: begin
                if (tdone) begin
                    d.sh   = {q.sh[7:0], q.i2};
                    d.lvl  = ~q.lvl;
                    d.bits = q.bits - 4'h1;
                    d.dat  = q.sh[7];
                    d.tmr  = SCK_HALF_LD;
                    d.st   = H_SETUP;
                    if (q.bits == 4'h1) begin
                        d.done = 1'b1;
                        d.st   = H_IDLE;
                        if (q.tw) begin
                            d.dat  = 1'b1;
                            d.rx   = q.sh[7:0];
                            d.ackr = q.i2;
                        end else begin
                            d.rx   = {q.sh[6:0], q.i2};
                        end
                    end
                end
            end
            H_STA: begin
                if (tdone && q.k2) begin
                    d.tmr = SCK_HALF_LD;
                    if (q.ph == 2'h0) begin
                        d.dat = 1'b0;
                        d.ph  = 2'h1;
                    end else begin
                        d.lvl  = 1'b0;
                        d.done = 1'b1;
                        d.st   = H_IDLE;
                    end
                end
            end
            H_STO: begin
                if (tdone) begin
                    if (q.ph == 2'h0) begin
                        d.lvl = 1'b1;
                        d.ph  = 2'h1;
                    end else if (q.k2) begin
                        d.dat  = 1'b1;
                        d.done = 1'b1;
                        d.st   = H_IDLE;
                    end
                end
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
        // Two-wire lines are open drain; three-wire lines are driven
        d.o_sck    = d.tw ? 1'b0 : d.lvl;
        d.o_sck_oe = d.tw ? ~d.lvl : 1'b1;
        d.o_dat    = d.tw ? 1'b0 : d.dat;
        d.o_dat_oe = d.tw ? ~d.dat : 1'b1;
        if (rst_i) begin
            d     = '0;
            d.lvl = 1'b1;
            d.dat = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    assign cmd_ready_o   = q.ready;
    assign done_o        = q.done;
    assign rx_o          = q.rx;
    assign ack_rx_o      = q.ackr;
    assign link.m_sck    = q.o_sck;
    assign link.m_sck_oe = q.o_sck_oe;
    assign link.m_dat    = q.o_dat;
    assign link.m_dat_oe = q.o_dat_oe;

endmodule
`default_nettype wire

/* design/usu_link_if.sv */
// Pin-level link between the shift unit and its far end
`timescale 1ns/100ps
`default_nettype none
interface usu_link_if (
    input wire logic link_clk
);
    logic m_sck;
    logic m_sck_oe;
    logic m_dat;
    logic m_dat_oe;
    logic d_sck;
    logic d_sck_oe;
    logic d_di;
    logic d_di_oe;
    logic d_do;
    logic d_do_oe;
    logic sck_line;
    logic di_line;
    logic do_line;

    // Undriven lines float high; any low driver pulls the line low
    assign sck_line = (m_sck_oe ? m_sck : 1'b1) & (d_sck_oe ? d_sck : 1'b1);
    assign di_line  = (m_dat_oe ? m_dat : 1'b1) & (d_di_oe ? d_di : 1'b1);
    assign do_line  = d_do_oe ? d_do : 1'b1;

    modport dev (
        input  link_clk, sck_line, di_line,
        output d_sck, d_sck_oe, d_di, d_di_oe, d_do, d_do_oe
    );
    modport host (
        input  sck_line, di_line, do_line,
        output m_sck, m_sck_oe, m_dat, m_dat_oe
    );
endinterface
`default_nettype wire

/* design/usu_pkg.sv */
// Shared constants for the universal serial shift unit and its far end
package usu_pkg;

    // ************************************************************
    // Widths, modes and sources
    // ************************************************************
    localparam int         DATA_W     = 8;
    localparam int         CNT_W      = 4;
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_3W    = 2'h1;
    localparam logic [1:0] MODE_2W    = 2'h2;
    localparam logic [1:0] SRC_PIN    = 2'h0;
    localparam logic [1:0] SRC_TIMER  = 2'h1;
    localparam logic [1:0] SRC_SOFT   = 2'h2;
    localparam logic [3:0] CNT_LAST   = 4'hf;
    localparam logic [3:0] CNT_ACK    = 4'he;
    localparam logic [7:0] DATA_RST   = 8'h00;

    // ************************************************************
    // Far end commands and timing
    // ************************************************************
    localparam logic [1:0] CMD_XFER   = 2'h0;
    localparam logic [1:0] CMD_START  = 2'h1;
    localparam logic [1:0] CMD_BYTE   = 2'h2;
    localparam logic [1:0] CMD_STOP   = 2'h3;
    localparam logic [3:0] XFER_BITS  = 4'h8;
    localparam logic [3:0] FRAME_BITS = 4'h9;
    localparam int         CLK_NS     = 40;
    localparam int         SCK_HALF_NS = 200;
    localparam int         SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] SCK_HALF_LD = 3'(SCK_HALF_CYC - 1);

endpackage

/* sim/testbench.sv */
// Bench joining the shift unit and its far end over the link
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import usu_pkg::*;
    logic       clk_i = 1'b0;
    logic       link_clk = 1'b0;
    logic       rst_i = 1'b1;
    logic [1:0] mode = MODE_OFF;
    logic [1:0] src = SRC_PIN;
    logic [1:0] cmd = CMD_XFER;
    logic [7:0] dat = 8'h00;
    logic [7:0] tx = 8'h00;
    logic [6:0] stb = 7'h00;
    logic       es = 1'b0;
    logic       dir_do = 1'b0;
    logic       tw = 1'b0;
    logic       hv = 1'b0;
    logic [7:0] sr, cp, rx, dv, tv;
    logic [3:0] cnto;
    logic       ovf, sf, hold, wake, hr, done, ackrx;
    int         n_fail = 0;
    int         cmp_count = 0;
    int         k;
    // ********
    // Design and link
    // ********
    usu_link_if lk (.link_clk(link_clk));
    usu_dev usu_dev_i (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .clk_src_i(src), .edge_select_bit_i(es),
        .dir_do_i(dir_do), .dir_sck_i(1'b0), .data_wr_i(stb[0]), .data_i(dat), .cnt_wr_i(stb[1]),
        .cnt_i(dat[3:0]), .clr_ovf_i(stb[2]), .clr_start_i(stb[3]), .clock_toggle_strobe_i(stb[6]),
        .soft_clk_i(stb[4]), .timer_zero_match_i(stb[5]), .serial_shift_register_o(sr),
        .shift_copy_register_o(cp), .cnt_o(cnto), .counter_overflow_flag_o(ovf), .start_detect_flag_o(sf),
        .hold_o(hold), .wake_o(wake), .link(lk));
    usu_host usu_host_i (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(hv), .cmd_i(cmd), .tx_i(tx),
        .ack_bit_i(1'b1), .two_wire_i(tw), .edge_select_bit_i(es), .cmd_ready_o(hr), .done_o(done),
        .rx_o(rx), .ack_rx_o(ackrx), .link(lk));
    usu_sva usu_sva_i (.link_clk(link_clk), .rst_i(rst_i), .mode_i(mode), .edge_select_bit_i(es),
        .sck_line(lk.sck_line), .di_line(lk.di_line), .d_sck(lk.d_sck), .d_sck_oe(lk.d_sck_oe),
        .d_di(lk.d_di), .d_di_oe(lk.d_di_oe), .d_do(lk.d_do), .d_do_oe(lk.d_do_oe));
    initial forever #20 clk_i = ~clk_i;
    initial #3 forever #6 link_clk = ~link_clk;
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Strobes: 0 data, 1 count, 2 clear overflow, 3 clear start, 4 soft tick, 5 timer tick, 6 toggle
    task automatic sw(input int s, input logic [7:0] v);
        @(negedge clk_i);
        dat = v;
        stb[s] = 1'b1;
        @(negedge clk_i);
        stb = 7'h00;
        repeat (24) @(negedge clk_i);
    endtask
    task automatic hcmd(input logic [1:0] c, input logic [7:0] t);
        int n;
        @(negedge clk_i);
        cmd = c;
        tx = t;
        hv = 1'b1;
        for (n = 0; hr !== 1'b1 && n < 99; n++) @(negedge clk_i);
        if (hr !== 1'b1) n_fail++;
        @(negedge clk_i);
        hv = 1'b0;
        for (n = 0; done !== 1'b1 && n < 9999; n++) @(negedge clk_i);
        if (done !== 1'b1) n_fail++;
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        n_fail++;
        print_verdict();
    end
    // ********
    // Tests
    // ********
    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        // Rest in the off mode first so the quiet-pin check gets to run
        repeat (40) @(negedge clk_i);
        mode = MODE_3W;
        dir_do = 1'b1;
        for (int e = 0; e < 2; e++) begin
            es = e[0];
            dv = e ? 8'h81 : 8'ha5;
            tv = e ? 8'h7e : 8'h3c;
            sw(0, dv);
            sw(1, 8'h00);
            sw(2, 8'h00);
            hcmd(CMD_XFER, tv);
            repeat (30) @(negedge clk_i);
            chk("host_rx", rx, dv);
            chk("dev_shift", sr, tv);
            chk("copy", cp, tv);
            chk("count", 8'(cnto), 8'h00);
            chk("ovf", 8'(ovf), 8'h01);
            chk("wake", 8'(wake), 8'h01);
        end
        for (int s = 1; s < 3; s++) begin
            src = s[1:0];
            sw(2, 8'h00);
            sw(1, 8'h0e);
            sw(6 - s, 8'h00);
            chk("tick_count", 8'(cnto), 8'h0f);
            chk("tick_ovf", 8'(ovf), 8'h00);
            sw(6 - s, 8'h00);
            chk("wrap_count", 8'(cnto), 8'h00);
            chk("wrap_ovf", 8'(ovf), 8'h01);
        end
        sw(6, 8'h00);
        chk("toggle_high", 8'(lk.d_sck), 8'h01);
        sw(6, 8'h00);
        chk("toggle_low", 8'(lk.d_sck), 8'h00);
        src = SRC_PIN;
        mode = MODE_2W;
        dir_do = 1'b0;
        tw = 1'b1;
        es = 1'b0;
        sw(2, 8'h00);
        hcmd(CMD_START, 8'h00);
        repeat (30) @(negedge clk_i);
        chk("start_flag", 8'(sf), 8'h01);
        chk("start_hold", 8'(hold), 8'h01);
        sw(1, 8'h00);
        sw(3, 8'h00);
        fork
            hcmd(CMD_BYTE, 8'ha2);
            begin
                for (k = 0; ovf !== 1'b1 && k < 9999; k++) @(negedge clk_i);
                if (ovf !== 1'b1) n_fail++;
                repeat (30) @(negedge clk_i);
                chk("address", sr, 8'ha2);
                chk("byte_hold", 8'(hold), 8'h01);
                dir_do = 1'b1;
                sw(0, 8'h00);
                sw(1, CNT_ACK);
                sw(2, 8'h00);
            end
        join
        repeat (30) @(negedge clk_i);
        chk("ack_seen", 8'(ackrx), 8'h00);
        chk("ack_hold", 8'(hold), 8'h01);
        dir_do = 1'b0;
        sw(2, 8'h00);
        hcmd(CMD_STOP, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire

/* sim/usu_sva.sv */
// Pin-level checks on the link between the shift unit and its far end
`timescale 1ns/100ps
`default_nettype none
module usu_sva
    import usu_pkg::*;
(
    // Clock and reset
    input wire logic       link_clk,
    input wire logic       rst_i,
    // Device configuration
    input wire logic [1:0] mode_i,
    input wire logic       edge_select_bit_i,
    // Link
    input wire logic       sck_line,
    input wire logic       di_line,
    input wire logic       d_sck,
    input wire logic       d_sck_oe,
    input wire logic       d_di,
    input wire logic       d_di_oe,
    input wire logic       d_do,
    input wire logic       d_do_oe
);
    logic [6:0] stab_q;
    logic [2:0] cfg_q;
    logic       ok;
    logic       ok2;
    logic       ok3;
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (rst_i);
    // ********
    // Configuration settle time
    // ********
    always_ff @(posedge link_clk) begin
        cfg_q <= {mode_i, edge_select_bit_i};
        stab_q <= (rst_i || cfg_q != {mode_i, edge_select_bit_i}) ? 7'h00 : stab_q + {6'h00, !stab_q[6]};
    end
    assign ok = stab_q[6] && cfg_q == {mode_i, edge_select_bit_i};
    assign ok2 = ok && mode_i == MODE_2W;
    assign ok3 = ok && mode_i == MODE_3W;
    // ********
    // Properties
    // ********
    sequence start_s;
        ok2 && sck_line && $fell(di_line);
    endsequence
    sequence sample_s;
        ok3 && (edge_select_bit_i ? $fell(sck_line) : $rose(sck_line));
    endsequence
    a_drain_low: assert property (d_di_oe |-> !d_di && !d_do) else $error("data line driven high");
    a_sck_low: assert property (d_sck_oe |-> !d_sck) else $error("clock driven high");
    a_three_wire_pins: assert property (ok3 |-> !d_di_oe && !d_sck_oe) else $error("line driver in 3W");
    a_two_wire_do: assert property (ok2 |-> !d_do_oe) else $error("output pin in 2W");
    a_off_quiet: assert property (ok && mode_i == MODE_OFF |-> !(d_do_oe || d_di_oe || d_sck_oe))
        else $error("driver while off");
    a_out_held: assert property (sample_s |-> $stable(d_do) [*4]) else $error("output moved on sample");
    a_start_hold: assert property (start_s ##[1:60] $fell(sck_line) |-> ##[0:6] d_sck_oe)
        else $error("no hold after start");
    a_hold_kept: assert property ($rose(d_sck_oe) |-> d_sck_oe [*8]) else $error("hold dropped");
endmodule
`default_nettype wire
